// file: dcks_device.sv
// device end: cke history, command decode and bank/burst state
//
// Overview of operation
// - next action from cke now, cke before, state
// - cke fall with nop enters power-down from idle or active
// - self refresh entered only from idle
// - self refresh exits on cke rise with nop
// - controller sends deselect in place of reads during read-exit delay
// - controller avoids power-down during busy operations
// - cke level held three registered edges
// - no own refresh while powered down
// - odt driven valid in power-down if enabled
// - odt ignored for cke states, off in self refresh
// - cke held high during driver calibration
// - unlisted combinations flagged illegal
// - data mask high inhibits that beat
// - idle command actions, read/write illegal
// - banks-active command actions
// - burst continues on nop; others illegal
// - no command interrupts a burst; any but nop or deselect is illegal
// - commands decoded from pins at edge
// - length-four bursts not interruptible
`default_nettype none
module dcks_device
    import dcks_pkg::*;
(
    input  wire logic                   mclk_in,
    input  wire logic                   resetn_in,
    dcks_if.dev                         pins,
    output var  dcks_pkg::dcks_state_t  state_out,
    output var  logic [7:0]             bank_open_out,
    output var  logic                   illegal_out,
    output var  logic                   cke_viol_out,
    output var  logic                   odt_active_out,
    output var  logic                   wr_strobe_out,
    output var  logic [2:0]             wr_bank_out,
    output var  logic [7:0]             wr_data_out,
    output var  logic                   ref_busy_out,
    output var  logic [7:0]             xsrd_left_out
);
    import dcks_pkg::*;
    // =====================================================
    // command decode
    dcks_state_t state_q;
    logic [7:0]  open_q;
    logic        cke_prev_q;
    logic [1:0]  cke_hold_q;
    logic [1:0]  burst_q;
    logic [3:0]  cmd;
    logic        is_nop;
    logic        cke_now;
    dcks_state_t state_d;
    logic        illegal_d;

    // pins are on the same clock as the controller, so no synchroniser
    assign cke_now = pins.cke;
    assign cmd     = pins.cs_n ? DCKS_CMD_DSL
                               : {1'b0, pins.ras_n, pins.cas_n, pins.we_n};
    assign is_nop  = (cmd == DCKS_CMD_DSL) || (cmd == DCKS_CMD_NOP);

    // =====================================================
    // next state
    always_comb
    begin
        state_d   = state_q;
        illegal_d = 1'b0;
        unique case ({cke_prev_q, cke_now})
            2'b00:
            begin
                if (!(state_q inside {DCKS_ST_PDN_PRE, DCKS_ST_PDN_ACT, DCKS_ST_SELF_REF}))
                    illegal_d = 1'b1;
            end
            2'b01:
            begin
                if (!is_nop)
                    illegal_d = 1'b1;
                else if (state_q == DCKS_ST_SELF_REF)
                    state_d = DCKS_ST_IDLE;
                else if (state_q == DCKS_ST_PDN_PRE)
                    state_d = DCKS_ST_IDLE;
                else if (state_q == DCKS_ST_PDN_ACT)
                    state_d = DCKS_ST_ACTIVE;
                else
                    illegal_d = 1'b1;
            end
            2'b10:
            begin
                if (is_nop && state_q == DCKS_ST_IDLE)
                    state_d = DCKS_ST_PDN_PRE;
                else if (is_nop && state_q == DCKS_ST_ACTIVE)
                    state_d = DCKS_ST_PDN_ACT;
                else if (cmd == DCKS_CMD_REF && state_q == DCKS_ST_IDLE)
                    state_d = DCKS_ST_SELF_REF;
                else
                    illegal_d = 1'b1;
            end
            2'b11:
            begin
                unique case (state_q)
                    DCKS_ST_IDLE:
                    begin
                        if (cmd == DCKS_CMD_ACT)
                            state_d = DCKS_ST_ACTIVE;
                        else if (cmd == DCKS_CMD_RD || cmd == DCKS_CMD_WR)
                            illegal_d = 1'b1;
                    end
                    DCKS_ST_ACTIVE:
                    begin
                        if (cmd == DCKS_CMD_RD && open_q[pins.ba])
                            state_d = DCKS_ST_READ;
                        else if (cmd == DCKS_CMD_WR && open_q[pins.ba])
                            state_d = DCKS_ST_WRITE;
                        else if (cmd == DCKS_CMD_PRE)
                        begin
                            if (pins.addr[10] || open_q == (8'h01 << pins.ba))
                                state_d = DCKS_ST_IDLE;
                        end
                        else if (cmd == DCKS_CMD_ACT && !open_q[pins.ba])
                            state_d = DCKS_ST_ACTIVE;
                        else if (!is_nop)
                            illegal_d = 1'b1;
                    end
                    DCKS_ST_READ, DCKS_ST_WRITE:
                    begin
                        if (!is_nop)
                            illegal_d = 1'b1;
                        else if (burst_q == 2'h0)
                            state_d = DCKS_ST_ACTIVE;
                    end
                    default:
                        illegal_d = 1'b1;
                endcase
            end
        endcase
        if (illegal_d)
            state_d = state_q;
    end

    // =====================================================
    // state, bank and burst registers
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            state_q    <= DCKS_ST_IDLE;
            cke_prev_q <= 1'b0;
        end
        else
        begin
            state_q    <= state_d;
            cke_prev_q <= cke_now;
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            open_q <= 8'h00;
        else if (!illegal_d && cke_prev_q && cke_now)
        begin
            if (state_q == DCKS_ST_IDLE && cmd == DCKS_CMD_ACT)
                open_q <= 8'h01 << pins.ba;
            else if (state_q == DCKS_ST_ACTIVE && cmd == DCKS_CMD_ACT)
                open_q <= open_q | (8'h01 << pins.ba);
            else if (state_q == DCKS_ST_ACTIVE && cmd == DCKS_CMD_PRE)
                open_q <= pins.addr[10] ? 8'h00 : (open_q & ~(8'h01 << pins.ba));
        end
    end

    // burst of four: start loads the count, every cycle counts down
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            burst_q <= 2'h0;
        else if (state_d inside {DCKS_ST_READ, DCKS_ST_WRITE} && state_q == DCKS_ST_ACTIVE)
            burst_q <= DCKS_BURST_LEN;
        else if (burst_q != 2'h0)
            burst_q <= burst_q - 2'h1;
    end

    // =====================================================
    // cke pulse width check
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            cke_hold_q   <= 2'h0;
            cke_viol_out <= 1'b0;
        end
        else if (cke_now != cke_prev_q)
        begin
            cke_hold_q   <= DCKS_CKE_CNT;
            cke_viol_out <= (cke_hold_q != 2'h0);
        end
        else
        begin
            if (cke_hold_q != 2'h0)
                cke_hold_q <= cke_hold_q - 2'h1;
            cke_viol_out <= 1'b0;
        end
    end

    // =====================================================
    // write data with mask, termination, outputs
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            wr_strobe_out  <= 1'b0;
            wr_bank_out    <= 3'h0;
            wr_data_out    <= 8'h00;
            odt_active_out <= 1'b0;
            illegal_out    <= 1'b0;
            state_out      <= DCKS_ST_IDLE;
            bank_open_out  <= 8'h00;
            ref_busy_out   <= 1'b0;
        end
        else
        begin
            // masked beats never reach the array
            wr_strobe_out  <= (state_q == DCKS_ST_WRITE) && !pins.dm && pins.dqs;
            wr_data_out    <= pins.dq;
            if (state_d == DCKS_ST_WRITE && state_q == DCKS_ST_ACTIVE)
                wr_bank_out <= pins.ba;
            odt_active_out <= pins.odt && (state_q != DCKS_ST_SELF_REF);
            illegal_out    <= illegal_d;
            state_out      <= state_q;
            bank_open_out  <= open_q;
            // only self refresh refreshes internally; power-down does not
            ref_busy_out   <= (state_q == DCKS_ST_SELF_REF);
        end
    end

    // read-exit delay count after self refresh, informational
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            xsrd_left_out <= 8'h00;
        else if (state_q == DCKS_ST_SELF_REF && state_d == DCKS_ST_IDLE)
            xsrd_left_out <= DCKS_XSRD_CNT;
        else if (xsrd_left_out != 8'h00)
            xsrd_left_out <= xsrd_left_out - 8'h01;
    end
endmodule : dcks_device
`default_nettype wire

// file: dcks_pkg.sv
// package: command codes, states and timing counts for the dram cke/command logic
`default_nettype none
package dcks_pkg;
    // =====================================================
    // command encoding {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] DCKS_CMD_NOP  = 4'h7;
    localparam logic [3:0] DCKS_CMD_ACT  = 4'h3;
    localparam logic [3:0] DCKS_CMD_RD   = 4'h5;
    localparam logic [3:0] DCKS_CMD_WR   = 4'h4;
    localparam logic [3:0] DCKS_CMD_PRE  = 4'h2;
    localparam logic [3:0] DCKS_CMD_REF  = 4'h1;
    localparam logic [3:0] DCKS_CMD_MRS  = 4'h0;
    localparam logic [3:0] DCKS_CMD_DSL  = 4'h8;
    // =====================================================
    // geometry and timing
    localparam int         DCKS_BANKS       = 8;
    localparam int         DCKS_BA_W        = 3;
    localparam int         DCKS_ROW_W       = 14;
    localparam int         DCKS_DQ_W        = 8;
    localparam int         DCKS_CKE_MIN_CLK = 3;
    localparam int         DCKS_XSRD_CLK    = 200;
    localparam logic [1:0] DCKS_BURST_LEN   = 2'h3;
    localparam logic [7:0] DCKS_XSRD_CNT    = 8'(DCKS_XSRD_CLK);
    localparam logic [1:0] DCKS_CKE_CNT     = 2'(DCKS_CKE_MIN_CLK - 1);
    // =====================================================
    typedef enum logic [2:0] {
        DCKS_ST_IDLE,
        DCKS_ST_ACTIVE,
        DCKS_ST_READ,
        DCKS_ST_WRITE,
        DCKS_ST_PDN_PRE,
        DCKS_ST_PDN_ACT,
        DCKS_ST_SELF_REF
    } dcks_state_t;
endpackage : dcks_pkg
`default_nettype wire

// file: dcks_if.sv
// interface: command, clock-enable, termination and write data pins
`default_nettype none
interface dcks_if;
    logic       cke;
    logic       cs_n;
    logic       ras_n;
    logic       cas_n;
    logic       we_n;
    logic [2:0] ba;
    logic [13:0] addr;
    logic       odt;
    logic [7:0] dq;
    logic       dm;
    logic       dqs;
    modport dev (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, dq, dm, dqs);
    modport ctl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, dq, dm, dqs);
endinterface : dcks_if
`default_nettype wire

// file: dcks_ctrl.sv
// controller end: turns user requests into pin sequences, enforcing cke timing and the read-exit delay
`default_nettype none
module dcks_ctrl
    import dcks_pkg::*;
(
    input  wire logic        mclk_in,
    input  wire logic        resetn_in,
    dcks_if.ctl              pins,
    input  wire logic        req_valid_in,
    input  wire logic [3:0]  req_cmd_in,
    input  wire logic [2:0]  req_ba_in,
    input  wire logic [13:0] req_addr_in,
    input  wire logic        req_cke_in,
    input  wire logic        req_odt_in,
    input  wire logic        req_dm_in,
    input  wire logic [7:0]  req_dq_in,
    input  wire logic        busy_op_in,
    input  wire logic        ocd_cal_in,
    output var  logic        req_ready_out
);
    import dcks_pkg::*;
    // =====================================================
    logic [1:0] hold_q;
    logic [7:0] xsrd_q;
    logic       cke_q;
    logic       cke_want;
    logic       cke_move;
    logic       is_read;
    logic [2:0] beat_q;
    logic       issue;

    // calibration and busy operations pin cke high
    assign cke_want = req_cke_in || ocd_cal_in || busy_op_in;
    assign cke_move = req_valid_in && (cke_want != cke_q) && (hold_q == 2'h0);
    assign is_read  = (req_cmd_in == DCKS_CMD_RD);

    // comb process so the function's read of cke_want is seen
    always_comb
    begin
        issue = req_valid_in && !(is_read && xsrd_q != 8'h00)
                && !(cke_move && cmd_bad(req_cmd_in));
    end

    // write beats: dqs marks the four data beats after a write
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            beat_q <= 3'h0;
        else if (issue && req_cmd_in == DCKS_CMD_WR)
            beat_q <= 3'(DCKS_BURST_LEN) + 3'h1;
        else if (beat_q != 3'h0)
            beat_q <= beat_q - 3'h1;
    end

    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            cke_q <= 1'b0;
            hold_q <= 2'h0;
        end
        else if (cke_move)
        begin
            cke_q  <= cke_want;
            hold_q <= DCKS_CKE_CNT;
        end
        else if (hold_q != 2'h0)
            hold_q <= hold_q - 2'h1;
    end

    // read blocked until the exit delay, reloaded on every cke rise, has run out
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            xsrd_q <= 8'h00;
        else if (cke_move && cke_want)
            xsrd_q <= DCKS_XSRD_CNT;
        else if (xsrd_q != 8'h00)
            xsrd_q <= xsrd_q - 8'h01;
    end

    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            pins.cs_n <= 1'b1;
            pins.ras_n <= 1'b1;
            pins.cas_n <= 1'b1;
            pins.we_n <= 1'b1;
            pins.ba <= 3'h0;
            pins.addr <= 14'h0000;
            pins.odt <= 1'b0;
            pins.dq <= 8'h00;
            pins.dm <= 1'b1;
            pins.dqs <= 1'b0;
            pins.cke <= 1'b0;
            req_ready_out <= 1'b0;
        end
        else
        begin
            pins.cke <= cke_move ? cke_want : cke_q;
            // odt always at a valid level, even in power-down
            pins.odt <= req_odt_in;
            pins.dq <= req_dq_in;
            pins.dm <= req_dm_in;
            pins.dqs <= (beat_q != 3'h0);
            pins.ba <= req_ba_in;
            pins.addr <= req_addr_in;
            if (issue)
                {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= req_cmd_in;
            else
                {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= DCKS_CMD_DSL;
            req_ready_out <= !(is_read && xsrd_q != 8'h00);
        end
    end

    // on a cke rise only deselect or nop may travel with it
    function automatic logic cmd_bad(input logic [3:0] c);
        cmd_bad = cke_want && c != DCKS_CMD_NOP && c != DCKS_CMD_DSL;
    endfunction : cmd_bad
endmodule : dcks_ctrl
`default_nettype wire

// file: dcks_asserts.sv
// checker: concurrent assertions on the pin interface and device status
`default_nettype none
module dcks_asserts
    import dcks_pkg::*;
(
    input wire logic                  mclk_in,
    input wire logic                  resetn_in,
    input wire logic                  cke,
    input wire logic                  cs_n,
    input wire logic                  ras_n,
    input wire logic                  cas_n,
    input wire logic                  we_n,
    input wire logic                  dm,
    input wire logic                  dqs,
    input wire dcks_pkg::dcks_state_t state_out,
    input wire logic                  ref_busy_out,
    input wire logic                  odt_active_out,
    input wire logic                  wr_strobe_out,
    input wire logic [7:0]            xsrd_left_out
);
    import dcks_pkg::*;
    // =====================================================
    // decoded pin command
    logic [3:0] cmd;
    logic       is_nop;
    logic       sr_cmd;
    assign cmd    = {cs_n, ras_n, cas_n, we_n};
    assign is_nop = cs_n | (cmd == DCKS_CMD_NOP);
    assign sr_cmd = !cke && (cmd == DCKS_CMD_REF);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);
    // =====================================================
    // sequences and properties
    sequence s_in_self_ref;
        ##[0:2] (state_out == DCKS_ST_SELF_REF);
    endsequence
    sequence s_cke_settled;
        $stable(cke) [*2];
    endsequence
    property p_cke_hold;
        $changed(cke) |=> s_cke_settled;
    endproperty
    property p_cke_edge_cmd;
        $changed(cke) |-> (is_nop || sr_cmd);
    endproperty
    property p_sr_entry;
        $rose(ref_busy_out) |-> $past(sr_cmd, 2) && $past(cke, 3);
    endproperty
    property p_sr_state;
        $rose(ref_busy_out) |-> s_in_self_ref;
    endproperty
    property p_sr_hold;
        ref_busy_out && !cke |=> ref_busy_out;
    endproperty
    property p_sr_exit;
        $fell(ref_busy_out) |-> $past(cke && is_nop, 2) && $past(!cke, 3);
    endproperty
    property p_odt_sr;
        ref_busy_out && $past(ref_busy_out) |-> !odt_active_out;
    endproperty
    property p_dm_inhibit;
        wr_strobe_out |-> $past(!dm && dqs);
    endproperty
    property p_xsrd_no_read;
        (xsrd_left_out > 8'h02) |-> (cmd != DCKS_CMD_RD);
    endproperty
    a_cke_hold: assert property (p_cke_hold)
        else $error("cke changed before three registered edges");
    a_cke_edge_cmd: assert property (p_cke_edge_cmd)
        else $error("cke transition with a command other than nop or refresh");
    a_sr_entry: assert property (p_sr_entry)
        else $error("self refresh without refresh on cke fall");
    a_sr_state: assert property (p_sr_state)
        else $error("self refresh flag without self refresh state");
    a_sr_hold: assert property (p_sr_hold)
        else $error("self refresh left while cke low");
    a_sr_exit: assert property (p_sr_exit)
        else $error("self refresh left without cke rise and nop");
    a_odt_sr: assert property (p_odt_sr)
        else $error("termination active in self refresh");
    a_dm_inhibit: assert property (p_dm_inhibit)
        else $error("write beat stored while masked");
    a_xsrd_no_read: assert property (p_xsrd_no_read)
        else $error("read issued inside read exit delay");
endmodule : dcks_asserts
`default_nettype wire

// file: dcks_bench.sv
// testbench: controller and device joined through the pin interface
`default_nettype none
module dcks_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import dcks_pkg::*;
    // =====================================================
    // signals
    logic        mclk_in = 1'b0, resetn_in = 1'b0, req_valid_in, req_cke_in, req_odt_in;
    logic        req_dm_in, req_ready_out, illegal_out, odt_active_out, wr_strobe_out;
    logic        ref_busy_out, busy_op_in, ocd_cal_in, cke_viol_out;
    logic [3:0]  req_cmd_in;
    logic [2:0]  req_ba_in, wr_bank_out;
    logic [13:0] req_addr_in;
    logic [7:0]  req_dq_in, bank_open_out, wr_data_out, xsrd_left_out, last_wd;
    dcks_state_t state_out;
    int          n_mismatch = 0, n_tests = 0, n_ill = 0, n_wr = 0, n_cyc = 0, i0;
    int          n_viol = 0;
    dcks_if dcks_if_i ();
    always #5 mclk_in = ~mclk_in;
    dcks_ctrl dcks_ctrl_i (.mclk_in(mclk_in), .resetn_in(resetn_in), .pins(dcks_if_i.ctl),
        .req_valid_in(req_valid_in), .req_cmd_in(req_cmd_in), .req_ba_in(req_ba_in),
        .req_addr_in(req_addr_in), .req_cke_in(req_cke_in), .req_odt_in(req_odt_in),
        .req_dm_in(req_dm_in), .req_dq_in(req_dq_in), .busy_op_in(busy_op_in),
        .ocd_cal_in(ocd_cal_in), .req_ready_out(req_ready_out));
    dcks_device dcks_device_i (.mclk_in(mclk_in), .resetn_in(resetn_in),
        .pins(dcks_if_i.dev), .state_out(state_out), .bank_open_out(bank_open_out),
        .illegal_out(illegal_out), .cke_viol_out(cke_viol_out),
        .odt_active_out(odt_active_out), .wr_strobe_out(wr_strobe_out),
        .wr_bank_out(wr_bank_out), .wr_data_out(wr_data_out),
        .ref_busy_out(ref_busy_out), .xsrd_left_out(xsrd_left_out));
    dcks_asserts dcks_asserts_i (.mclk_in(mclk_in), .resetn_in(resetn_in),
        .cke(dcks_if_i.cke), .cs_n(dcks_if_i.cs_n), .ras_n(dcks_if_i.ras_n),
        .cas_n(dcks_if_i.cas_n), .we_n(dcks_if_i.we_n), .dm(dcks_if_i.dm),
        .dqs(dcks_if_i.dqs), .state_out(state_out), .ref_busy_out(ref_busy_out),
        .odt_active_out(odt_active_out), .wr_strobe_out(wr_strobe_out),
        .xsrd_left_out(xsrd_left_out));
    // =====================================================
    // pulse counters and hang limit
    always @(posedge mclk_in)
    begin
        n_cyc++;
        if (illegal_out === 1'b1)
            n_ill++;
        if (cke_viol_out === 1'b1)
            n_viol++;
        if (wr_strobe_out === 1'b1)
        begin
            n_wr++;
            last_wd = wr_data_out;
        end
        if (n_cyc == 6000)
        begin
            n_mismatch++;
            test_done();
        end
    end
    // =====================================================
    // tasks
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // one request per falling edge; valid stays up for back-to-back use
    task automatic send(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a,
                        input logic k, input logic m = 1'b1, input logic [7:0] d = 8'h00);
        req_valid_in = 1'b1;
        req_cmd_in = c;
        req_ba_in = b;
        req_addr_in = a;
        req_cke_in = k;
        req_dm_in = m;
        req_dq_in = d;
        @(negedge mclk_in);
    endtask : send
    task automatic idle(input int n);
        req_valid_in = 1'b0;
        repeat (n) @(negedge mclk_in);
    endtask : idle
    task automatic wait_ready();
        repeat (400) if (req_ready_out !== 1'b1) @(negedge mclk_in);
    endtask : wait_ready
    task automatic test_done();
        if (n_mismatch == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done
    // =====================================================
    // main sequence
    initial
    begin
        req_valid_in = 1'b0;
        req_cmd_in = DCKS_CMD_DSL;
        req_ba_in = 3'h0;
        req_addr_in = 14'h0000;
        req_cke_in = 1'b0;
        req_odt_in = 1'b0;
        busy_op_in = 1'b0;
        ocd_cal_in = 1'b0;
        req_dm_in = 1'b1;
        req_dq_in = 8'h00;
        repeat (3) @(negedge mclk_in);
        resetn_in = 1'b1;
        send(DCKS_CMD_NOP, 3'h0, 14'h0000, 1'b1);
        // ready only reflects the exit delay for a pending read
        req_cmd_in = DCKS_CMD_RD;
        idle(5);
        chk("ready_blocked", 8'h00, {7'h00, req_ready_out});
        wait_ready();
        chk("ready", 8'h01, {7'h00, req_ready_out});
        i0 = n_ill;
        send(DCKS_CMD_RD, 3'h0, 14'h0000, 1'b1);
        send(DCKS_CMD_WR, 3'h0, 14'h0000, 1'b1);
        idle(4);
        chk("idle_rw", 8'h02, 8'(n_ill - i0));
        chk("idle_state", 8'(DCKS_ST_IDLE), 8'(state_out));
        send(DCKS_CMD_ACT, 3'h2, 14'h0123, 1'b1);
        idle(4);
        chk("act_state", 8'(DCKS_ST_ACTIVE), 8'(state_out));
        chk("act_bank", 8'h04, bank_open_out);
        i0 = n_ill;
        send(DCKS_CMD_ACT, 3'h2, 14'h0000, 1'b1);
        send(DCKS_CMD_MRS, 3'h0, 14'h0000, 1'b1);
        send(DCKS_CMD_REF, 3'h0, 14'h0000, 1'b1);
        idle(4);
        chk("active_illegal", 8'h03, 8'(n_ill - i0));
        chk("active_bank", 8'h04, bank_open_out);
        i0 = n_wr;
        send(DCKS_CMD_WR, 3'h2, 14'h0000, 1'b1);
        for (int k = 0; k < 4; k++)
            send(DCKS_CMD_NOP, 3'h2, 14'h0000, 1'b1, k[0], 8'ha0 + 8'(k));
        idle(6);
        chk("write_beats", 8'h02, 8'(n_wr - i0));
        chk("write_data", 8'ha2, last_wd);
        chk("write_bank", 8'h02, {5'h00, wr_bank_out});
        i0 = n_ill;
        send(DCKS_CMD_WR, 3'h2, 14'h0000, 1'b1);
        send(DCKS_CMD_PRE, 3'h2, 14'h0000, 1'b1);
        send(DCKS_CMD_RD, 3'h2, 14'h0000, 1'b1);
        idle(6);
        chk("wr_burst_illegal", 8'h02, 8'(n_ill - i0));
        i0 = n_ill;
        send(DCKS_CMD_RD, 3'h2, 14'h0000, 1'b1);
        send(DCKS_CMD_RD, 3'h2, 14'h0000, 1'b1);
        send(DCKS_CMD_ACT, 3'h5, 14'h0000, 1'b1);
        idle(6);
        chk("rd_burst_illegal", 8'h02, 8'(n_ill - i0));
        send(DCKS_CMD_NOP, 3'h0, 14'h0000, 1'b0);
        idle(5);
        chk("pdn_act", 8'(DCKS_ST_PDN_ACT), 8'(state_out));
        send(DCKS_CMD_NOP, 3'h0, 14'h0000, 1'b1);
        idle(5);
        chk("pdn_act_exit", 8'(DCKS_ST_ACTIVE), 8'(state_out));
        send(DCKS_CMD_PRE, 3'h0, 14'h0400, 1'b1);
        idle(4);
        chk("pre_all", 8'h00, bank_open_out);
        ocd_cal_in = 1'b1;
        send(DCKS_CMD_NOP, 3'h0, 14'h0000, 1'b0);
        idle(5);
        chk("ocd_cke", 8'h01, {7'h00, dcks_if_i.cke});
        ocd_cal_in = 1'b0;
        busy_op_in = 1'b1;
        send(DCKS_CMD_NOP, 3'h0, 14'h0000, 1'b0);
        idle(5);
        chk("busy_cke", 8'(DCKS_ST_IDLE), 8'(state_out));
        busy_op_in = 1'b0;
        send(DCKS_CMD_NOP, 3'h0, 14'h0000, 1'b0);
        idle(5);
        chk("pdn_pre", 8'(DCKS_ST_PDN_PRE), 8'(state_out));
        send(DCKS_CMD_NOP, 3'h0, 14'h0000, 1'b1);
        idle(5);
        chk("pdn_pre_exit", 8'(DCKS_ST_IDLE), 8'(state_out));
        req_odt_in = 1'b1;
        send(DCKS_CMD_REF, 3'h0, 14'h0000, 1'b0);
        idle(5);
        chk("sr_state", 8'(DCKS_ST_SELF_REF), 8'(state_out));
        chk("sr_busy", 8'h01, {7'h00, ref_busy_out});
        chk("sr_odt", 8'h00, {7'h00, odt_active_out});
        req_odt_in = 1'b0;
        send(DCKS_CMD_NOP, 3'h0, 14'h0000, 1'b1);
        req_cmd_in = DCKS_CMD_RD;
        idle(5);
        chk("sr_exit", 8'h00, {7'h00, ref_busy_out});
        chk("sr_exit_count", 8'(DCKS_XSRD_CLK - 4), xsrd_left_out);
        chk("sr_exit_state", 8'(DCKS_ST_IDLE), 8'(state_out));
        chk("sr_exit_ready", 8'h00, {7'h00, req_ready_out});
        i0 = n_ill;
        send(DCKS_CMD_RD, 3'h0, 14'h0000, 1'b1);
        idle(4);
        chk("sr_read_held", 8'h00, 8'(n_ill - i0));
        wait_ready();
        chk("sr_ready", 8'h01, {7'h00, req_ready_out});
        send(DCKS_CMD_ACT, 3'h1, 14'h0010, 1'b1);
        idle(4);
        send(DCKS_CMD_REF, 3'h0, 14'h0000, 1'b0);
        idle(5);
        chk("sr_from_active", 8'h00, {7'h00, ref_busy_out});
        chk("cke_viol", 8'h00, 8'(n_viol));
        test_done();
    end
endmodule : dcks_bench
`default_nettype wire
